//--- rtl/refdiv_pkg.sv
// shared constants for the link reference divider and termination calibration bank
`default_nettype none
package refdiv_pkg;
	// ************************************************
	// register access widths and map
	// ************************************************
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam logic [14:0] ADDR_REF_DIVIDER = 15'h0289;
	localparam logic [14:0] ADDR_CAL_START = 15'h02A7;
	localparam logic [14:0] ADDR_OVERRIDE = 15'h02A8;
	localparam logic [14:0] ADDR_READBACK = 15'h02AC;

	// ************************************************
	// field layout and reset values
	// ************************************************
	localparam int RATIO_LSB = 0;
	localparam int RATIO_W = 2;
	localparam int KICK_BIT = 0;
	localparam int OVR_ENABLE_BIT = 4;
	localparam int OVR_CODE_LSB = 1;
	localparam int TRIM_W = 3;
	localparam int CODE_W = 4;
	localparam logic [1:0] RST_REF_DIVIDER = 2'h0;
	localparam logic RST_CAL_START = 1'b0;
	localparam logic [7:0] RST_OVERRIDE = 8'h00;
	localparam logic [3:0] RST_CODE = 4'h0;

	// ************************************************
	// reference ratio codes and divider terminal counts
	// ************************************************
	localparam logic [1:0] RATIO_DIV4 = 2'h0;
	localparam logic [1:0] RATIO_DIV2 = 2'h1;
	localparam logic [1:0] RATIO_DIV1 = 2'h2;
	localparam logic [1:0] RATIO_UNUSED = 2'h3;
	localparam logic [1:0] DIV4_LAST = 2'h3;
	localparam logic [1:0] DIV2_LAST = 2'h1;
	localparam logic [1:0] DIV1_LAST = 2'h0;

	// ************************************************
	// serial frame: 16 instruction bits then 8 data bits
	// ************************************************
	localparam logic [4:0] INSTR_BITS = 5'h10;
	localparam logic [4:0] FRAME_BITS = 5'h18;

	// ************************************************
	// calibration timing
	// ************************************************
	localparam int CLOCK_MHZ = 250;
	localparam int SETTLE_NS = 100;
	localparam int SETTLE_CYCLES = (SETTLE_NS * CLOCK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

//--- rtl/reg_access_if.sv
// register access strobes between the serial port and the register bank
`default_nettype none
interface reg_access_if;
	logic wr_stb;
	logic rd_stb;
	logic [refdiv_pkg::ADDR_W-1:0] addr;
	logic [refdiv_pkg::DATA_W-1:0] wdata;
	logic [refdiv_pkg::DATA_W-1:0] rdata;
	modport port (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
	modport bank (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- rtl/spi_reg_port.sv
// serial register port: samples the host pins and issues register strobes
`default_nettype none
module spi_reg_port import refdiv_pkg::*; (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	reg_access_if.port bus
);
	localparam int PIN_SCLK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_SDI = 2;

	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic sclk_prev_q;
	logic [4:0] bit_cnt_q;
	logic [15:0] shift_q;
	logic read_q;
	logic [DATA_W-1:0] out_q;
	logic rd_stb_q;
	logic wr_stb_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic active;
	logic rise;
	logic fall;

	// two-stage synchronisers; the first stage feeds nothing but the second
	genvar g;
	for (g = 0; g < 3; g++) begin : gen_sync
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				pin_meta_q[g] <= (g == PIN_CS);
				pin_sync_q[g] <= (g == PIN_CS);
			end else begin
				pin_meta_q[g] <= (g == PIN_SCLK) ? spi_sclk : (g == PIN_CS) ? spi_cs_n : spi_sdi;
				pin_sync_q[g] <= pin_meta_q[g];
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) sclk_prev_q <= 1'b0;
		else sclk_prev_q <= pin_sync_q[PIN_SCLK];
	end

	assign active = !pin_sync_q[PIN_CS];
	assign rise = active && pin_sync_q[PIN_SCLK] && !sclk_prev_q;
	assign fall = active && !pin_sync_q[PIN_SCLK] && sclk_prev_q;

	// frame shifter; bits past the data byte are ignored until select rises
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_q <= '0;
			shift_q <= '0;
			read_q <= 1'b0;
			addr_q <= '0;
		end else if (!active) begin
			bit_cnt_q <= '0;
			read_q <= 1'b0;
		end else if (rise && bit_cnt_q != FRAME_BITS) begin
			shift_q <= {shift_q[14:0], pin_sync_q[PIN_SDI]};
			bit_cnt_q <= bit_cnt_q + 5'h01;
			if (bit_cnt_q == INSTR_BITS - 5'h01) begin
				addr_q <= {shift_q[ADDR_W-2:0], pin_sync_q[PIN_SDI]};
				read_q <= shift_q[ADDR_W-1];
			end
		end
	end

	// one-cycle strobes: read after the instruction, write after the data byte
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_stb_q <= 1'b0;
			wr_stb_q <= 1'b0;
			wdata_q <= '0;
		end else begin
			rd_stb_q <= rise && bit_cnt_q == INSTR_BITS - 5'h01 && shift_q[ADDR_W-1];
			wr_stb_q <= rise && bit_cnt_q == FRAME_BITS - 5'h01 && !read_q;
			if (rise && bit_cnt_q == FRAME_BITS - 5'h01)
				wdata_q <= {shift_q[DATA_W-2:0], pin_sync_q[PIN_SDI]};
		end
	end

	// read data leaves msb first on falling edges, as mode 0 hosts expect
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			out_q <= '0;
			spi_sdo <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else if (!active) begin
			spi_sdo <= 1'b0;
			spi_sdo_oe <= 1'b0;
		end else if (rd_stb_q) begin
			out_q <= bus.rdata;
		end else if (fall && read_q && bit_cnt_q >= INSTR_BITS && bit_cnt_q < FRAME_BITS) begin
			spi_sdo <= out_q[DATA_W-1];
			out_q <= {out_q[DATA_W-2:0], 1'b0};
			spi_sdo_oe <= 1'b1;
		end
	end

	assign bus.rd_stb = rd_stb_q;
	assign bus.wr_stb = wr_stb_q;
	assign bus.addr = addr_q;
	assign bus.wdata = wdata_q;
endmodule
`default_nettype wire

//--- rtl/term_cal_engine.sv
// successive-approximation termination calibration for one block
`default_nettype none
module term_cal_engine import refdiv_pkg::*; #(
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic start,
	input wire logic cmp_pin,
	output logic [CODE_W-1:0] trial_code,
	output logic [CODE_W-1:0] result_code,
	output logic busy
);
	// limitation: the comparator answer arrives three cycles after the trial code,
	// so SETTLE below 3 makes each decision on the previous trial
	localparam int TW = $clog2(SETTLE + 1);
	localparam int RUN_CYCLES = CODE_W * (SETTLE + 1);

	typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_DECIDE} cal_state_type;
	cal_state_type state_q;
	logic [TW-1:0] timer_q;
	logic [1:0] idx_q;
	logic cmp_meta_q;
	logic cmp_sync_q;
	logic [CODE_W-1:0] decided;
	logic [15:0] run_cnt_q;

	// comparator is analog-side, so it is synchronised first
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cmp_meta_q <= 1'b0;
			cmp_sync_q <= 1'b0;
		end else begin
			cmp_meta_q <= cmp_pin;
			cmp_sync_q <= cmp_meta_q;
		end
	end

	// comparator high keeps the trial bit, low drops it
	always_comb begin
		decided = trial_code;
		decided[idx_q] = trial_code[idx_q] & cmp_sync_q;
	end

	// sequencing: each bit settles, then is decided; starts during a run are ignored
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ST_IDLE;
			timer_q <= '0;
			idx_q <= '0;
			busy <= 1'b0;
			trial_code <= RST_CODE;
			result_code <= RST_CODE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						trial_code <= RST_CODE;
						trial_code[CODE_W-1] <= 1'b1;
						idx_q <= 2'(CODE_W - 1);
						timer_q <= TW'(SETTLE - 1);
						busy <= 1'b1;
						state_q <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					if (timer_q == '0) state_q <= ST_DECIDE;
					else timer_q <= timer_q - 1'b1;
				end
				ST_DECIDE: begin
					if (idx_q == '0) begin
						result_code <= decided;
						trial_code <= decided;
						busy <= 1'b0;
						state_q <= ST_IDLE;
					end else begin
						trial_code <= decided;
						trial_code[idx_q - 2'h1] <= 1'b1;
						idx_q <= idx_q - 2'h1;
						timer_q <= TW'(SETTLE - 1);
						state_q <= ST_SETTLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// helper: length of the current run
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) run_cnt_q <= '0;
		else if (!busy) run_cnt_q <= '0;
		else run_cnt_q <= run_cnt_q + 16'h0001;
	end

	a_run_length: assert property (@(posedge clock) disable iff (!arst_n)
		$fell(busy) |-> run_cnt_q == 16'(RUN_CYCLES))
		else $error("calibration run length wrong");
endmodule
`default_nettype wire

//--- rtl/serdes_refdiv_termination_cal.sv
// link reference divider and termination block A calibration register bank
// ************************************************
// ************************************************
`default_nettype none
module serdes_refdiv_termination_cal import refdiv_pkg::*; #(
	parameter int SETTLE = SETTLE_CYCLES
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	input wire logic term_a_cmp,
	output logic link_pll_pfd_tick,
	output logic [CODE_W-1:0] term_a_code,
	output logic term_a_cal_busy
);
	reg_access_if regs ();

	logic [RATIO_W-1:0] ref_ratio_q;
	logic kick_q;
	logic kick_prev_q;
	logic [DATA_W-1:0] override_q;
	logic [1:0] div_cnt_q;
	logic pfd_tick_q;
	logic [CODE_W-1:0] term_code_q;
	logic [CODE_W-1:0] cal_trial;
	logic [CODE_W-1:0] cal_result;
	logic cal_busy;
	logic cal_start;
	logic ratio_wr;
	logic [CODE_W-1:0] code_in_effect;
	logic [2:0] gap_q;
	logic gap_valid_q;

	// ************************************************
	// helpers
	// ************************************************

	// terminal count of the divider for each ratio code
	function automatic logic [1:0] div_last(input logic [RATIO_W-1:0] ratio);
		case (ratio)
			RATIO_DIV4: return DIV4_LAST;
			RATIO_DIV2: return DIV2_LAST;
			RATIO_DIV1: return DIV1_LAST;
			default: return DIV4_LAST; // unused code falls back to the slowest ratio
		endcase
	endfunction

	// termination code selected by the override byte
	function automatic logic [CODE_W-1:0] select_code(input logic [DATA_W-1:0] ovr,
		input logic [CODE_W-1:0] auto_code);
		logic [CODE_W-1:0] forced;
		forced = '0;
		forced[TRIM_W-1:0] = ovr[OVR_CODE_LSB +: TRIM_W];
		return ovr[OVR_ENABLE_BIT] ? forced : auto_code;
	endfunction

	// ************************************************
	// leaf instances
	// ************************************************

	spi_reg_port u_spi (
		.clock(clock),
		.arst_n(arst_n),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe),
		.bus(regs.port)
	);

	term_cal_engine #(.SETTLE(SETTLE)) u_cal (
		.clock(clock),
		.arst_n(arst_n),
		.start(cal_start),
		.cmp_pin(term_a_cmp),
		.trial_code(cal_trial),
		.result_code(cal_result),
		.busy(cal_busy)
	);

	// ************************************************
	// register writes
	// ************************************************

	assign ratio_wr = regs.wr_stb && regs.addr == ADDR_REF_DIVIDER;

	// only the ratio field is stored; the upper bits are dropped
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) ref_ratio_q <= RST_REF_DIVIDER;
		else if (ratio_wr) ref_ratio_q <= regs.wdata[RATIO_LSB +: RATIO_W];
	end

	// kick bit is level storage; its history gives the rising edge
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			kick_q <= RST_CAL_START;
			kick_prev_q <= RST_CAL_START;
		end else begin
			if (regs.wr_stb && regs.addr == ADDR_CAL_START)
				kick_q <= regs.wdata[KICK_BIT];
			kick_prev_q <= kick_q;
		end
	end

	// full byte is writable; it reaches block A only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) override_q <= RST_OVERRIDE;
		else if (regs.wr_stb && regs.addr == ADDR_OVERRIDE) override_q <= regs.wdata;
	end

	// ************************************************
	// register reads
	// ************************************************

	assign code_in_effect = select_code(override_q, cal_result);

	// unmapped and reserved positions return zero
	always_comb begin
		regs.rdata = '0;
		case (regs.addr)
			ADDR_REF_DIVIDER: regs.rdata[RATIO_LSB +: RATIO_W] = ref_ratio_q;
			ADDR_CAL_START: regs.rdata[KICK_BIT] = kick_q;
			ADDR_OVERRIDE: regs.rdata = override_q;
			ADDR_READBACK: regs.rdata[CODE_W-1:0] = code_in_effect;
			default: regs.rdata = '0;
		endcase
	end

	// ************************************************
	// reference divider
	// ************************************************

	// a write to the ratio restarts the count so no short period escapes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_q <= '0;
			pfd_tick_q <= 1'b0;
		end else if (ratio_wr) begin
			div_cnt_q <= '0;
			pfd_tick_q <= 1'b0;
		end else if (div_cnt_q >= div_last(ref_ratio_q)) begin
			div_cnt_q <= '0;
			pfd_tick_q <= 1'b1;
		end else begin
			div_cnt_q <= div_cnt_q + 2'h1;
			pfd_tick_q <= 1'b0;
		end
	end

	assign link_pll_pfd_tick = pfd_tick_q;

	// ************************************************
	// calibration start and termination code
	// ************************************************

	// a held level gives no edge; an edge during a run is dropped
	assign cal_start = kick_q && !kick_prev_q && !cal_busy;

	// during a run the trial code drives the termination so the comparator sees it
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) term_code_q <= RST_CODE;
		else if (cal_busy) term_code_q <= cal_trial;
		else term_code_q <= code_in_effect;
	end

	assign term_a_code = term_code_q;
	assign term_a_cal_busy = cal_busy;

	// ************************************************
	// checks
	// ************************************************

	// helper: cycles between divider ticks, valid only while the ratio is left alone
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gap_q <= '0;
			gap_valid_q <= 1'b0;
		end else begin
			if (pfd_tick_q) gap_q <= 3'h1;
			else if (gap_q != 3'h7) gap_q <= gap_q + 3'h1;
			if (ratio_wr) gap_valid_q <= 1'b0;
			else if (pfd_tick_q) gap_valid_q <= 1'b1;
		end
	end

	a_div4_gap: assert property (@(posedge clock) disable iff (!arst_n)
		pfd_tick_q && gap_valid_q && ref_ratio_q == RATIO_DIV4 |-> gap_q == 3'h4)
		else $error("divide by four period wrong");

	a_div2_gap: assert property (@(posedge clock) disable iff (!arst_n)
		pfd_tick_q && gap_valid_q && ref_ratio_q == RATIO_DIV2 |-> gap_q == 3'h2)
		else $error("divide by two period wrong");

	a_div1_tick: assert property (@(posedge clock) disable iff (!arst_n)
		ref_ratio_q == RATIO_DIV1 && !ratio_wr ##1 !ratio_wr |-> pfd_tick_q[*2])
		else $error("undivided reference missing ticks");

	a_unused_ratio: assert property (@(posedge clock) disable iff (!arst_n)
		pfd_tick_q && gap_valid_q && ref_ratio_q == RATIO_UNUSED |-> gap_q == 3'h4)
		else $error("unused ratio code not held at slowest rate");

	a_ratio_restart: assert property (@(posedge clock) disable iff (!arst_n)
		ratio_wr |=> !pfd_tick_q && div_cnt_q == 2'h0)
		else $error("ratio write did not restart divider");

	a_kick_edge: assert property (@(posedge clock) disable iff (!arst_n)
		kick_q && !kick_prev_q && !cal_busy |=> cal_busy)
		else $error("kick edge did not start a run");

	a_kick_level: assert property (@(posedge clock) disable iff (!arst_n)
		!cal_busy && kick_q && kick_prev_q |=> !cal_busy)
		else $error("held kick level started a run");

	a_auto_select: assert property (@(posedge clock) disable iff (!arst_n)
		!override_q[OVR_ENABLE_BIT] && !cal_busy |=> term_a_code == $past(cal_result))
		else $error("automatic code not applied");

	a_force_select: assert property (@(posedge clock) disable iff (!arst_n)
		override_q[OVR_ENABLE_BIT] && !cal_busy
		|=> term_a_code == {1'b0, $past(override_q[OVR_CODE_LSB +: TRIM_W])})
		else $error("forced code not applied");

	a_code_readback: assert property (@(posedge clock) disable iff (!arst_n)
		regs.rd_stb && regs.addr == ADDR_READBACK
		|-> regs.rdata == {4'h0, select_code(override_q, cal_result)} && regs.rdata[7:4] == 4'h0)
		else $error("readback does not show code in effect");

	a_reserved_zero: assert property (@(posedge clock) disable iff (!arst_n)
		regs.rd_stb && regs.addr == ADDR_REF_DIVIDER |-> regs.rdata[7:2] == 6'h00)
		else $error("reserved ratio bits not zero");

	a_override_hold: assert property (@(posedge clock) disable iff (!arst_n)
		!(regs.wr_stb && regs.addr == ADDR_OVERRIDE) |=> $stable(override_q))
		else $error("override byte changed without its write");
endmodule
`default_nettype wire

//--- bench/spi_host_model.sv
// host-side serial port model that frames register reads and writes
`default_nettype none
module spi_host_model import refdiv_pkg::*; #(
	parameter int HALF = 6
) (
	input wire logic clock,
	output var logic spi_sclk,
	output var logic spi_cs_n,
	output var logic spi_sdi,
	input wire logic spi_sdo,
	input wire logic spi_sdo_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// ************************************************
	// idle pins
	// ************************************************
	// serial clock parked low between frames, select released
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end

	// ************************************************
	// frame driver
	// ************************************************
	// pins always move just after a system clock edge
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// 16 instruction bits then 8 data bits, msb first, sampled on sclk rise
	task automatic xfer(input logic rd, input logic [ADDR_W-1:0] addr,
			input logic [DATA_W-1:0] wdata, output logic [DATA_W-1:0] rdata,
			output logic oe_on, output logic oe_off);
		logic [23:0] frame;
		frame = {rd, addr, wdata};
		rdata = '0;
		oe_on = 1'b1;
		wait_clk(1);
		spi_cs_n = 1'b0;
		wait_clk(4); // select must clear the sync flops before the first edge
		for (int i = 23; i >= 0; i--) begin
			spi_sdi = frame[i];
			wait_clk(HALF);
			// read data was launched on the previous fall, so it has settled
			if (i < 8) begin
				rdata[i] = spi_sdo;
				oe_on = oe_on & (spi_sdo_oe === 1'b1);
			end
			spi_sclk = 1'b1;
			wait_clk(HALF);
			spi_sclk = 1'b0;
		end
		wait_clk(HALF);
		spi_cs_n = 1'b1;
		spi_sdi = ~spi_sdi; // released data line must not keep looking valid
		wait_clk(8);
		oe_off = (spi_sdo_oe === 1'b0);
	endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the reference divider and termination calibration bank
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
	$display("unexpected at %0t ns: got %0h, expected %0h", $time, (got), (exp)); end end
module tb_top import refdiv_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	// the settle count must outlast the code flop and the two comparator sync flops,
	// so 3 is the least that works; 4 leaves one cycle of margin
	localparam int SETTLE_T = 4;
	localparam int CAL_LEN = 4 * (SETTLE_T + 1);
	logic clock;
	logic arst_n;
	logic spi_sclk;
	logic spi_cs_n;
	logic spi_sdi;
	logic spi_sdo;
	logic spi_sdo_oe;
	logic term_a_cmp;
	logic link_pll_pfd_tick;
	logic [CODE_W-1:0] term_a_code;
	logic term_a_cal_busy;
	logic [CODE_W-1:0] target;
	int error_cnt = 0;
	int total_checks = 0;
	int busy_cycles = 0;
	int cycles = 0;

	// ************************************************
	// design, host and comparator
	// ************************************************
	serdes_refdiv_termination_cal #(.SETTLE(SETTLE_T)) u_serdes_refdiv_termination_cal (
		.clock(clock),
		.arst_n(arst_n),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe),
		.term_a_cmp(term_a_cmp),
		.link_pll_pfd_tick(link_pll_pfd_tick),
		.term_a_code(term_a_code),
		.term_a_cal_busy(term_a_cal_busy)
	);
	spi_host_model u_spi_host_model (
		.clock(clock),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe)
	);
	// comparator keeps a trial bit while the trial code is not above the target
	assign term_a_cmp = (term_a_code <= target);

	// ************************************************
	// clock, run length and busy watch
	// ************************************************
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	// busy cycles counted so a second run, or a short one, shows up
	always @(posedge clock) begin
		cycles++;
		if (term_a_cal_busy === 1'b1) busy_cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			give_verdict();
		end
	end

	// ************************************************
	// access tasks
	// ************************************************
	task automatic give_verdict();
		$display("checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		logic on;
		logic off;
		u_spi_host_model.xfer(1'b0, a, d, r, on, off);
	endtask
	// read data and output-enable behaviour are both checked on every read
	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] r;
		logic on;
		logic off;
		u_spi_host_model.xfer(1'b1, a, 8'h00, r, on, off);
		`CHK(r, exp)
		`CHK({on, off}, 2'b11)
	endtask
	// cycles from one pfd tick to the next, sampled on falling edges
	task automatic period_chk(input int exp);
		int n;
		n = 0;
		@(negedge clock);
		while (link_pll_pfd_tick !== 1'b1 && n < 16) begin
			@(negedge clock);
			n++;
		end
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (link_pll_pfd_tick !== 1'b1 && n < 16);
		`CHK(n, exp)
	endtask
	// bounded wait until the busy count reaches the given number of runs
	task automatic wait_runs(input int runs);
		int n;
		n = 0;
		while (busy_cycles < runs * CAL_LEN && n < 300) begin
			@(posedge clock);
			n++;
		end
		repeat (4) @(posedge clock);
		#1;
	endtask

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		arst_n = 1'b0;
		target = 4'h0;
		repeat (3) @(posedge clock);
		#1 arst_n = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		// reset values, then an unmapped address
		rd_chk(ADDR_REF_DIVIDER, 8'h00);
		rd_chk(ADDR_CAL_START, 8'h00);
		rd_chk(ADDR_OVERRIDE, 8'h00);
		rd_chk(ADDR_READBACK, 8'h00);
		rd_chk(15'h0300, 8'h00);
		period_chk(4);
		// host only programs 00, 01 and 10 so the comparison rate stays legal
		wr(ADDR_REF_DIVIDER, 8'h01);
		period_chk(2);
		rd_chk(ADDR_REF_DIVIDER, 8'h01);
		wr(ADDR_REF_DIVIDER, 8'hFE);
		period_chk(1);
		rd_chk(ADDR_REF_DIVIDER, 8'h02);
		wr(ADDR_REF_DIVIDER, 8'hFC);
		period_chk(4);
		rd_chk(ADDR_REF_DIVIDER, 8'h00);
		// every forced code, with ignored bits 7, 5 and 0 set around it
		for (int c = 0; c < 8; c++) begin
			wr(ADDR_OVERRIDE, {3'b101, 1'b1, c[2:0], 1'b1});
			`CHK(term_a_code, {1'b0, c[2:0]})
			rd_chk(ADDR_READBACK, {5'h00, c[2:0]});
		end
		rd_chk(ADDR_OVERRIDE, 8'hBF);
		wr(ADDR_OVERRIDE, 8'hEF);
		`CHK(term_a_code, 4'h0)
		// first calibration run
		target = 4'hB;
		wr(ADDR_CAL_START, 8'h01);
		wait_runs(1);
		`CHK(busy_cycles, CAL_LEN)
		`CHK(term_a_code, 4'hB)
		`CHK(term_a_cal_busy, 1'b0)
		rd_chk(ADDR_READBACK, 8'h0B);
		rd_chk(ADDR_CAL_START, 8'h01);
		// a level held high starts nothing
		target = 4'h3;
		wr(ADDR_CAL_START, 8'h01);
		repeat (100) @(posedge clock);
		#1;
		`CHK(busy_cycles, CAL_LEN)
		`CHK(term_a_code, 4'hB)
		// a fresh zero-to-one change, reserved bits written high
		wr(ADDR_CAL_START, 8'h00);
		wr(ADDR_CAL_START, 8'hFF);
		wait_runs(2);
		`CHK(busy_cycles, 2 * CAL_LEN)
		`CHK(term_a_code, 4'h3)
		rd_chk(ADDR_CAL_START, 8'h01);
		// forcing over a calibrated value, then back to automatic
		wr(ADDR_OVERRIDE, 8'h1A);
		`CHK(term_a_code, 4'h5)
		rd_chk(ADDR_READBACK, 8'h05);
		wr(ADDR_OVERRIDE, 8'h0E);
		`CHK(term_a_code, 4'h3)
		rd_chk(ADDR_READBACK, 8'h03);
		give_verdict();
	end
endmodule
`default_nettype wire
